// ---- rtl/flash_seq_pkg.sv ----
package flash_seq_pkg;

    // Command opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_AUTO_INC = 8'had;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_BUSY_OUT_EN = 8'h70;
    localparam logic [7:0] OP_BUSY_OUT_DIS = 8'h80;
    localparam logic [7:0] OP_ID_READ = 8'h88;
    localparam logic [7:0] OP_ID_LOCK = 8'h85;

    // Whole command lengths in bytes
    localparam logic [2:0] LEN_OPCODE = 3'h1;
    localparam logic [2:0] LEN_AAI_NEXT = 3'h3;
    localparam logic [2:0] LEN_ERASE = 3'h4;
    localparam logic [2:0] LEN_AAI_FIRST = 3'h6;

    // Byte index at which the id address is in or read data starts on the output
    localparam logic [2:0] STATUS_DATA_START = 3'h1;
    localparam logic [2:0] ID_ADDR_DONE = 3'h2;
    localparam logic [2:0] ID_DATA_START = 3'h3;

    // Erase region masks (low address bits that are ignored)
    localparam logic [23:0] SECTOR_MASK = 24'h000fff;
    localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
    localparam logic [23:0] BLOCK64_MASK = 24'h00ffff;

    // Security id space
    localparam logic [7:0] ID_LAST_ADDR = 8'h1f;
    localparam logic [7:0] ID_USER_FIRST = 8'h08;
    localparam logic [7:0] ID_FILL = 8'h00;

    // Status byte bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_AAI_BIT = 6;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [23:0] RST_ADDR = 24'h000000;

    // Self-timed operation times and system clock rate
    localparam int CLK_FREQ_KHZ = 40000;
    localparam int PROGRAM_TIME_US = 10;
    localparam int ID_PROGRAM_TIME_US = 10;
    localparam int SECTOR_ERASE_TIME_MS = 25;
    localparam int BLOCK_ERASE_TIME_MS = 25;
    localparam int CHIP_ERASE_TIME_MS = 50;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_FREQ_KHZ / 1000;
    localparam int ID_PROGRAM_CYCLES = ID_PROGRAM_TIME_US * CLK_FREQ_KHZ / 1000;
    localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_MS * CLK_FREQ_KHZ;
    localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_MS * CLK_FREQ_KHZ;
    localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_MS * CLK_FREQ_KHZ;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WR_LO = 2'b01,
        ST_WR_HI = 2'b10,
        ST_TIMED = 2'b11
    } seq_state_t;

    // Erase region kinds
    typedef enum logic [1:0] {
        ERASE_SECTOR = 2'b00,
        ERASE_BLOCK32 = 2'b01,
        ERASE_BLOCK64 = 2'b10,
        ERASE_CHIP = 2'b11
    } erase_kind_t;

endpackage : flash_seq_pkg

// ---- rtl/flash_program_erase_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_seq
    import flash_seq_pkg::*;
#(
    parameter int TIMER_W = 24,
    parameter logic [23:0] MEM_TOP = 24'hffffff,
    parameter int SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
    parameter int BLOCK_CYCLES = BLOCK_ERASE_CYCLES,
    parameter int CHIP_CYCLES = CHIP_ERASE_CYCLES,
    // Id space contents, byte n at bits 8n+7:8n; value is arbitrary
    parameter logic [255:0] ID_CONTENT = {32{8'h5a}}
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic prot_en_i,
    input wire logic [23:0] prot_base_i,
    output logic mem_wr_o,
    output logic mem_erase_o,
    output logic [1:0] erase_kind_o,
    output logic [23:0] mem_addr_o,
    output logic [7:0] mem_data_o,
    output logic busy_o,
    output logic wel_o,
    output logic aai_o,
    output logic busy_out_en_o,
    output logic id_locked_o
);

    // Link domain reset: power reset or deselect
    logic link_rstn;
    logic [2:0] bit_cnt; // Bit within the byte
    logic [2:0] byte_cnt; // Completed bytes, saturating
    logic [6:0] rx_shift; // Incoming bits
    logic [7:0] link_op; // Opcode seen by the link side
    logic [7:0] rx_byte; // Last whole byte, held for the crossing
    logic rx_toggle; // Flips once per whole byte
    logic [7:0] tx_shift; // Outgoing bits
    logic tx_active; // Read data is being driven
    logic [7:0] id_ptr; // Id read pointer
    logic [2:0] stat_s1; // Status bits into the link domain
    logic [2:0] stat_s2;
    logic [7:0] status_byte;

    assign link_rstn = rstn_i & ~cs_n_i;

    // Id byte lookup; past the last address reads as fill
    function automatic logic [7:0] id_byte(input logic [7:0] a);
        logic [7:0] v;
        v = ID_FILL;
        if (a <= ID_LAST_ADDR) begin
            v = ID_CONTENT[{a[4:0], 3'h0} +: 8];
        end
        return v;
    endfunction : id_byte

    // Region test: protected if any byte of it lies at or above the base
    function automatic logic hits_prot(input logic [23:0] a, input logic [23:0] m,
                                       input logic en, input logic [23:0] base);
        return en && ((a | m) >= base);
    endfunction : hits_prot

    // Shift in on rising clock; count bits and bytes per frame
    // eight clocks per byte
    always_ff @(posedge sck_i or negedge link_rstn) begin
        if (!link_rstn) begin
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            rx_shift <= 7'h00;
            link_op <= RST_BYTE;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_shift <= {rx_shift[5:0], si_i};
            if (bit_cnt == 3'h7) begin
                if (byte_cnt != 3'h7) begin
                    byte_cnt <= byte_cnt + 3'h1;
                end
                if (byte_cnt == 3'h0) begin
                    link_op <= {rx_shift, si_i};
                end
            end
        end
    end

    // Whole byte handed over with a toggle; held for eight clocks
    // most significant bit first
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_byte <= RST_BYTE;
            rx_toggle <= 1'b0;
        end else if (bit_cnt == 3'h7) begin
            rx_byte <= {rx_shift, si_i};
            rx_toggle <= ~rx_toggle;
        end
    end

    // Status bits synchronised onto the link clock
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_s1 <= 3'h0;
            stat_s2 <= 3'h0;
        end else begin
            stat_s1 <= {aai_o, wel_o, busy_o};
            stat_s2 <= stat_s1;
        end
    end

    // Status byte layout
    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_BUSY_BIT] = stat_s2[0];
        status_byte[ST_WEL_BIT] = stat_s2[1];
        status_byte[ST_AAI_BIT] = stat_s2[2];
    end

    // Read data shifted out on falling clock
    // id data after the dummy byte, status data right after the opcode
    // pointer runs to the end, then zeros
    always_ff @(negedge sck_i or negedge link_rstn) begin
        if (!link_rstn) begin
            tx_shift <= RST_BYTE;
            tx_active <= 1'b0;
            id_ptr <= RST_BYTE;
        end else if (bit_cnt == 3'h0 && byte_cnt != 3'h0) begin
            if (link_op == OP_STATUS_READ) begin
                tx_shift <= status_byte;
                tx_active <= 1'b1;
            end else if (link_op == OP_ID_READ && byte_cnt == ID_ADDR_DONE) begin
                id_ptr <= rx_byte;
            end else if (link_op == OP_ID_READ && byte_cnt >= ID_DATA_START) begin
                tx_shift <= id_byte(id_ptr);
                tx_active <= 1'b1;
                if (id_ptr <= ID_LAST_ADDR) begin
                    id_ptr <= id_ptr + 8'h01;
                end
            end
        end else begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    // Serial output: ready/busy in word mode, else read data
    // drive at select low, release at rise
    logic hw_drive;
    assign hw_drive = busy_out_en_o & aai_o;
    assign so_o = hw_drive ? ~busy_o : tx_shift[7];
    assign so_oe_o = ~cs_n_i & (hw_drive | tx_active);

    // System domain synchronisers
    logic cs_s1, cs_s2, cs_s3;
    logic tog_s1, tog_s2, tog_s3;
    logic mid_s1, mid_s2, mid_s3;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            mid_s1 <= 1'b0;
            mid_s2 <= 1'b0;
            mid_s3 <= 1'b0;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            tog_s1 <= rx_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            mid_s1 <= (bit_cnt != 3'h0);
            mid_s2 <= mid_s1;
            mid_s3 <= mid_s2;
        end
    end

    logic byte_new; // A whole byte arrived
    logic cs_rise; // Select just went high
    assign byte_new = tog_s2 ^ tog_s3;
    assign cs_rise = cs_s2 & ~cs_s3;

    // Command bytes gathered per frame
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data0, data1;
    logic [2:0] nbytes;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            opcode <= RST_BYTE;
            addr <= RST_ADDR;
            data0 <= RST_BYTE;
            data1 <= RST_BYTE;
            nbytes <= 3'h0;
        end else if (~cs_s2 & cs_s3) begin
            nbytes <= 3'h0;
        end else if (byte_new) begin
            if (nbytes != 3'h7) begin
                nbytes <= nbytes + 3'h1;
            end
            case (nbytes)
                3'h0: opcode <= rx_byte;
                3'h1: addr[23:16] <= rx_byte;
                3'h2: addr[15:8] <= rx_byte;
                3'h3: addr[7:0] <= rx_byte;
                3'h4: data0 <= rx_byte;
                3'h5: data1 <= rx_byte;
                default: ;
            endcase
        end
    end

    // Execute one cycle after cs_rise, so the last byte is in
    // self-timed work waits for select high
    // erase launched by the rising edge
    logic exec, cut;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            exec <= 1'b0;
            cut <= 1'b0;
        end else begin
            exec <= cs_rise;
            cut <= cs_rise & mid_s3;
        end
    end

    // Command decode at execution
    seq_state_t state;
    logic [23:0] aai_addr; // Next word address in word mode
    logic aai_full; // Limit reached, no wrap
    logic [23:0] limit;
    logic go, idle, start_prog, first_word, start_erase, start_lock;
    logic set_wel, clr_wel_mode, set_bout, clr_bout;
    erase_kind_t kind;
    logic [23:0] word_addr;
    logic [7:0] wd0, wd1;

    assign limit = prot_en_i ? (prot_base_i - 24'h000001) : MEM_TOP;
    assign idle = (state == ST_IDLE);

    always_comb begin
        go = exec & ~cut;
        start_prog = 1'b0;
        first_word = 1'b0;
        start_erase = 1'b0;
        start_lock = 1'b0;
        set_wel = 1'b0;
        clr_wel_mode = 1'b0;
        set_bout = 1'b0;
        clr_bout = 1'b0;
        kind = ERASE_SECTOR;
        word_addr = {addr[23:1], 1'b0};
        wd0 = data0;
        wd1 = data1;
        if (go) begin
            case (opcode)
                OP_WRITE_ENABLE: set_wel = (nbytes == LEN_OPCODE) & idle & ~aai_o;
                OP_WRITE_DISABLE: clr_wel_mode = (nbytes == LEN_OPCODE);
                OP_BUSY_OUT_EN: set_bout = (nbytes == LEN_OPCODE) & ~aai_o;
                OP_BUSY_OUT_DIS: clr_bout = (nbytes == LEN_OPCODE) & ~aai_o;
                OP_SECTOR_ERASE: begin
                    kind = ERASE_SECTOR;
                    start_erase = (nbytes == LEN_ERASE) & idle & wel_o & ~aai_o &
                        ~hits_prot(addr, SECTOR_MASK, prot_en_i, prot_base_i);
                end
                OP_BLOCK32_ERASE: begin
                    kind = ERASE_BLOCK32;
                    start_erase = (nbytes == LEN_ERASE) & idle & wel_o & ~aai_o &
                        ~hits_prot(addr, BLOCK32_MASK, prot_en_i, prot_base_i);
                end
                OP_BLOCK64_ERASE: begin
                    kind = ERASE_BLOCK64;
                    start_erase = (nbytes == LEN_ERASE) & idle & wel_o & ~aai_o &
                        ~hits_prot(addr, BLOCK64_MASK, prot_en_i, prot_base_i);
                end
                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                    kind = ERASE_CHIP;
                    start_erase = (nbytes == LEN_OPCODE) & idle & wel_o & ~aai_o &
                        ~prot_en_i;
                end
                OP_ID_LOCK: start_lock = (nbytes == LEN_OPCODE) & idle & wel_o &
                    ~aai_o & ~id_locked_o;
                OP_AUTO_INC: begin
                    if (!aai_o) begin
                        first_word = (nbytes == LEN_AAI_FIRST) & idle & wel_o &
                            ~hits_prot(addr, 24'h000001, prot_en_i, prot_base_i);
                        start_prog = first_word;
                    end else begin
                        word_addr = aai_addr;
                        wd0 = addr[23:16];
                        wd1 = addr[15:8];
                        start_prog = (nbytes == LEN_AAI_NEXT) & idle & ~aai_full;
                    end
                end
                // other opcodes have no effect here
                default: ;
            endcase
        end
    end

    // Sequencer: two byte writes, then the timed wait; erase and id lock go straight to the timed wait
    // even byte, then odd byte
    logic [TIMER_W-1:0] timer;
    logic [7:0] hi_byte;
    logic op_done;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            timer <= '0;
            hi_byte <= RST_BYTE;
            mem_wr_o <= 1'b0;
            mem_erase_o <= 1'b0;
            erase_kind_o <= ERASE_SECTOR;
            mem_addr_o <= RST_ADDR;
            mem_data_o <= RST_BYTE;
            op_done <= 1'b0;
        end else begin
            mem_wr_o <= 1'b0;
            mem_erase_o <= 1'b0;
            op_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_prog) begin
                        mem_wr_o <= 1'b1;
                        mem_addr_o <= word_addr;
                        mem_data_o <= wd0;
                        hi_byte <= wd1;
                        state <= ST_WR_LO;
                    end else if (start_erase) begin
                        mem_erase_o <= 1'b1;
                        erase_kind_o <= kind;
                        mem_addr_o <= (kind == ERASE_SECTOR) ? (addr & ~SECTOR_MASK) :
                            (kind == ERASE_BLOCK32) ? (addr & ~BLOCK32_MASK) :
                            (kind == ERASE_BLOCK64) ? (addr & ~BLOCK64_MASK) : RST_ADDR;
                        timer <= (kind == ERASE_CHIP) ? TIMER_W'(CHIP_CYCLES) :
                            (kind == ERASE_SECTOR) ? TIMER_W'(SECTOR_CYCLES) :
                            TIMER_W'(BLOCK_CYCLES);
                        state <= ST_TIMED;
                    end else if (start_lock) begin
                        timer <= TIMER_W'(ID_PROGRAM_CYCLES);
                        state <= ST_TIMED;
                    end
                end
                ST_WR_LO: begin
                    mem_wr_o <= 1'b1;
                    mem_addr_o <= {mem_addr_o[23:1], 1'b1};
                    mem_data_o <= hi_byte;
                    timer <= TIMER_W'(PROGRAM_CYCLES);
                    state <= ST_WR_HI;
                end
                ST_WR_HI: state <= ST_TIMED;
                ST_TIMED: begin
                    timer <= timer - 1'b1;
                    if (timer <= TIMER_W'(1)) begin
                        op_done <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign busy_o = ~idle;

    // Write enable latch
    // cleared at end of op, kept in word mode
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wel_o <= 1'b0;
        end else if (set_wel) begin
            wel_o <= 1'b1;
        end else if (clr_wel_mode || (op_done && !aai_o)) begin
            wel_o <= 1'b0;
        end
    end

    // Word mode flag, next address and limit
    // stop at the highest unprotected word
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aai_o <= 1'b0;
            aai_addr <= RST_ADDR;
            aai_full <= 1'b0;
        end else if (clr_wel_mode) begin
            aai_o <= 1'b0;
            aai_full <= 1'b0;
        end else if (start_prog) begin
            aai_o <= 1'b1;
            aai_addr <= word_addr + 24'h000002;
            aai_full <= ({word_addr[23:1], 1'b1} >= limit);
        end
    end

    // Busy-output routing and id lock
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_out_en_o <= 1'b0;
            id_locked_o <= 1'b0;
        end else begin
            if (set_bout) begin
                busy_out_en_o <= 1'b1;
            end else if (clr_bout) begin
                busy_out_en_o <= 1'b0;
            end
            if (start_lock) begin
                id_locked_o <= 1'b1;
            end
        end
    end

    // Checks
    default clocking chk_clk @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    byte_pair_a: assert property (mem_wr_o && state == ST_WR_LO |=>
        mem_wr_o && mem_addr_o[0] && $past(mem_addr_o[23:1]) == mem_addr_o[23:1])
        else $error("odd byte write does not follow even byte");
    wdis_clear_a: assert property (go && opcode == OP_WRITE_DISABLE && nbytes == LEN_OPCODE
        |=> !wel_o && !aai_o)
        else $error("write disable left latch or mode set");
    wen_set_a: assert property (go && opcode == OP_WRITE_ENABLE && nbytes == LEN_OPCODE
        && idle && !aai_o |=> wel_o)
        else $error("write enable did not set latch");
    need_wel_a: assert property (go && !wel_o && !aai_o && idle |=> idle)
        else $error("operation started without latch");
    chip_prot_a: assert property (go && prot_en_i && opcode == OP_CHIP_ERASE_A
        |=> !mem_erase_o)
        else $error("chip erase ran with protection on");
    partial_a: assert property (exec && cut && idle |=> idle ##1 idle)
        else $error("partial command started an operation");
    sector_align_a: assert property (mem_erase_o && erase_kind_o == ERASE_SECTOR
        |-> mem_addr_o[11:0] == 12'h000)
        else $error("sector erase base not aligned");
    erase_busy_a: assert property (mem_erase_o |-> busy_o [*8])
        else $error("busy dropped during erase");
    no_wrap_a: assert property (mem_wr_o |-> mem_addr_o <= limit || !aai_o)
        else $error("word program past limit");
    so_status_a: assert property (!cs_n_i && hw_drive |-> so_oe_o && so_o == (state == ST_IDLE))
        else $error("ready/busy output wrong");
    launch_a: assert property (start_erase |-> $past(cs_rise))
        else $error("erase launched before select rose");

    word_cov: cover property (go && first_word ##[1:900] go && start_prog);
    erase_cov: cover property (mem_erase_o ##[1:20] busy_o);
    wdis_cov: cover property (aai_o ##[1:1000] !aai_o);
    lock_cov: cover property (start_lock);

endmodule : flash_program_erase_seq
`default_nettype wire

// ---- bench/spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host end of the link; clock idles low outside frames
module spi_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    logic [47:0] rx; // Output bits, one per rising clock
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        rx = '0;
    end
    // Whole bytes, MSB first, then select rises; x extra bits cut it
    task automatic frame(input logic [47:0] d, input int n, input int x = 0);
        cs_n_o = 1'b0;
        for (int i = 47; i > 47 - 8 * n - x; i--) begin
            si_o = d[i];
            #15 sck_o = 1'b1;
            rx = {rx[46:0], so_i};
            #15 sck_o = 1'b0;
        end
        #15 cs_n_o = 1'b1;
        si_o = ~si_o;
    endtask : frame
    // Short select pulse to sample the output pin
    task automatic poll(output logic s);
        cs_n_o = 1'b0;
        #40 s = so_i;
        cs_n_o = 1'b1;
    endtask : poll
endmodule : spi_host
`default_nettype wire

// ---- bench/spi_flash_program_erase_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_flash_program_erase_sequencer_test;
    import flash_seq_pkg::*;
    logic clock_i, rstn_i, sck, cs_n, si, so, oe, pen, wr, er, busy, write_enable_latch, auto_increment_program, boe, s, lock;
    logic [1:0] kind;
    logic [23:0] pbase, addr;
    logic [7:0] data;
    logic [34:0] ev[$];
    logic [7:0] ops[4] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_CHIP_ERASE_B};
    logic [23:0] bases[4] = '{24'h012000, 24'h010000, 24'h010000, 24'h000000};
    int error_cnt = 0;
    int tests_run = 0;
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // Two top id bytes set apart so the read order shows
    flash_program_erase_seq #(.SECTOR_CYCLES(50), .BLOCK_CYCLES(50), .CHIP_CYCLES(50),
        .ID_CONTENT({8'h3c, 8'h96, 240'h0}))
        u_flash_program_erase_seq (.clock_i(clock_i), .rstn_i(rstn_i), .sck_i(sck),
        .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(oe), .prot_en_i(pen),
        .prot_base_i(pbase), .mem_wr_o(wr), .mem_erase_o(er), .erase_kind_o(kind),
        .mem_addr_o(addr), .mem_data_o(data), .busy_o(busy), .wel_o(write_enable_latch), .aai_o(auto_increment_program),
        .busy_out_en_o(boe), .id_locked_o(lock));
    // An undriven output reads as the inverse, so a missing enable shows
    spi_host u_spi_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(oe ? so : ~so));
    // Log array writes and erase starts
    always @(posedge clock_i) begin
        if (wr === 1'b1) ev.push_back({3'b000, addr, data});
        if (er === 1'b1) ev.push_back({1'b1, kind, addr, 8'h00});
    end
    task automatic final_report();
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Next logged event, zero when none
    task automatic pop(input string nm, input logic [34:0] e);
        logic [34:0] g;
        g = '0;
        if (ev.size() > 0) g = ev.pop_front();
        chk(nm, e, g);
    endtask : pop
    // Let a command launch, then wait for idle
    task automatic idle();
        repeat (8) @(posedge clock_i);
        #1;
        for (int i = 0; busy !== 1'b0; i++) begin
            if (i > 3000) begin
                error_cnt++;
                final_report();
            end
            @(posedge clock_i);
            #1;
        end
        // Let the latch settle after the operation ends
        repeat (2) @(posedge clock_i);
        #1;
    endtask : idle
    task automatic cmd(input logic [47:0] d, input int n);
        u_spi_host.frame(d, n);
        idle();
    endtask : cmd
    initial begin
        rstn_i = 1'b0;
        pen = 1'b0;
        pbase = 24'h100000;
        repeat (5) @(posedge clock_i);
        #1 rstn_i = 1'b1;
        repeat (3) @(posedge clock_i);
        cmd({OP_WRITE_ENABLE, 40'h0}, 1);
        chk("wel", 1, write_enable_latch);
        cmd({OP_AUTO_INC, 24'h000101, 16'ha1b2}, 6);
        pop("wr0", {3'b0, 24'h000100, 8'ha1});
        pop("wr1", {3'b0, 24'h000101, 8'hb2});
        cmd({OP_AUTO_INC, 16'hc3d4, 24'h0}, 3);
        pop("wr2", {3'b0, 24'h000102, 8'hc3});
        pop("wr3", {3'b0, 24'h000103, 8'hd4});
        cmd({OP_SECTOR_ERASE, 40'h0}, 4);
        pop("mode", 0);
        cmd({OP_WRITE_DISABLE, 40'h0}, 1);
        chk("aai_wel", 0, {auto_increment_program, write_enable_latch});
        cmd({OP_SECTOR_ERASE, 24'h0123ab, 16'h0}, 4);
        pop("nowel", 0);
        $display("word program test done");
        for (int i = 0; i < 4; i++) begin
            cmd({OP_WRITE_ENABLE, 40'h0}, 1);
            cmd({ops[i], 24'h0123ab, 16'h0}, (i == 3) ? 1 : 4);
            pop("erase", {1'b1, i[1:0], bases[i], 8'h00});
        end
        chk("wel_end", 0, write_enable_latch);
        $display("erase test done");
        @(posedge clock_i);
        #1 pen = 1'b1;
        cmd({OP_WRITE_ENABLE, 40'h0}, 1);
        cmd({OP_SECTOR_ERASE, 24'h1000ff, 16'h0}, 4);
        pop("prot_sec", 0);
        cmd({OP_CHIP_ERASE_A, 40'h0}, 1);
        pop("prot_chip", 0);
        cmd({OP_AUTO_INC, 24'h100000, 16'h0102}, 6);
        pop("prot_word", 0);
        pen = 1'b0;
        $display("protection test done");
        cmd({OP_BUSY_OUT_EN, 40'h0}, 1);
        chk("boe", 1, boe);
        cmd({OP_WRITE_ENABLE, 40'h0}, 1);
        u_spi_host.frame({OP_AUTO_INC, 24'h000200, 16'h1122}, 6);
        repeat (20) @(posedge clock_i);
        u_spi_host.poll(s);
        chk("so_busy", 0, s);
        idle();
        u_spi_host.poll(s);
        chk("so_ready", 1, s);
        pop("wr4", {3'b0, 24'h000200, 8'h11});
        pop("wr5", {3'b0, 24'h000201, 8'h22});
        cmd({OP_WRITE_DISABLE, 40'h0}, 1);
        cmd({OP_BUSY_OUT_DIS, 40'h0}, 1);
        chk("boe_off", 0, {boe, auto_increment_program});
        $display("busy output test done");
        pbase = 24'h000304;
        pen = 1'b1;
        cmd({OP_WRITE_ENABLE, 40'h0}, 1);
        cmd({OP_AUTO_INC, 24'h000302, 16'h5566}, 6);
        cmd({OP_AUTO_INC, 16'h7788, 24'h0}, 3);
        pop("lim0", {3'b0, 24'h000302, 8'h55});
        pop("lim1", {3'b0, 24'h000303, 8'h66});
        pop("nowrap", 0);
        cmd({OP_WRITE_DISABLE, 40'h0}, 1);
        pen = 1'b0;
        $display("limit test done");
        cmd({OP_WRITE_ENABLE, 40'h0}, 1);
        u_spi_host.frame({OP_SECTOR_ERASE, 24'h0123ab, 16'h0}, 4);
        repeat (10) @(posedge clock_i);
        #1 u_spi_host.frame({OP_STATUS_READ, 40'h0}, 2);
        chk("status", 8'h03, u_spi_host.rx[7:0]);
        idle();
        pop("erase2", {1'b1, 2'b00, 24'h012000, 8'h00});
        cmd({OP_WRITE_ENABLE, 40'h0}, 1);
        cmd({OP_ID_LOCK, 40'h0}, 1);
        chk("locked", 1, lock);
        chk("wel_lock", 0, write_enable_latch);
        u_spi_host.frame({OP_WRITE_ENABLE, 40'h0}, 1, 3);
        idle();
        chk("cut", 0, write_enable_latch);
        cmd({OP_ID_READ, 8'h1e, 32'h0}, 6);
        chk("id_read", {8'h96, 8'h3c, ID_FILL}, u_spi_host.rx[23:0]);
        $display("status and id test done");
        final_report();
    end
endmodule : spi_flash_program_erase_sequencer_test
`default_nettype wire
